// File: verilog/els_cfg.svh
// Constants for the link service originator: codes, payload layout, timing.
// Assumes one 250 MHz clock; included by bare name where needed.
`ifndef ELS_CFG_SVH
`define ELS_CFG_SVH

// Clock and timer base
`define CLK_PERIOD_NS 4
`define TICK_PERIOD_NS 1000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_CNT_W 8
`define TOV_W 24

// Command and reply codes
`define ELS_CMD_ADVC 8'h0D
`define ELS_CODE_ACC 8'h02
`define ELS_PAD_ZERO 24'h000000

// Advise credit payload layout (word indexes)
`define ADVC_WORDS 5'd29
`define ADVC_CMD_WORD 5'd0
`define ADVC_C2_WORD0 5'd13
`define ADVC_C2_CRED 5'd15
`define ADVC_C3_WORD0 5'd17
`define ADVC_C3_CRED 5'd19
`define CLS_VALID_BIT 31
`define CRED_W 16

// Framing and retries
`define FRAME_WORDS 3'd7
`define MAX_EXCH_RETRY 2'd3

`endif

// File: verilog/els_pkg.sv
// Types shared by the link service originator.
// Assumes els_cfg.svh holds the numeric constants.
`default_nettype none
package els_pkg;

    // Originator sequencing states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_SEND = 4'h1,
        ST_WAIT_REPLY = 4'h2,
        ST_SEND_ABTS = 4'h3,
        ST_WAIT_ABTS_ACK = 4'h4,
        ST_WAIT_BA = 4'h5,
        ST_SEND_ABTS_LS = 4'h6,
        ST_WAIT_LS_ACK = 4'h7,
        ST_FINISH = 4'h8
    } orig_state_e;

endpackage
`default_nettype wire

// File: verilog/els_timer.sv
// Microsecond timeout counter for reply and acknowledge waits.
// Assumes one clock; a start pulse reloads, expiry is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "els_cfg.svh"

module els_timer (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Control
    input wire logic i_start,
    input wire logic [`TOV_W:0] i_limit_us,
    // Status
    output logic o_expired
);

    logic [`TICK_CNT_W-1:0] tick_cnt; // Divider toward 1 us
    logic tick; // One-cycle microsecond enable
    logic [`TOV_W:0] us_cnt; // Microseconds left
    logic running; // Timer armed

    assign tick = (tick_cnt == `TICK_CNT_W'(`TICK_CYCLES - 1));

    // Microsecond divider, realigned on start
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt <= '0;
        end else if (i_start || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    // Countdown; a start always wins over a pending expiry
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            us_cnt <= '0;
            running <= 1'b0;
            o_expired <= 1'b0;
        end else if (i_start) begin
            us_cnt <= i_limit_us;
            running <= 1'b1;
            o_expired <= 1'b0;
        end else if (running && tick) begin
            // Zero limit expires on the first tick
            if (us_cnt <= 1) begin
                running <= 1'b0;
                o_expired <= 1'b1;
            end else begin
                us_cnt <= us_cnt - 1'b1;
                o_expired <= 1'b0;
            end
        end else begin
            o_expired <= 1'b0;
        end
    end

endmodule // els_timer
`default_nettype wire

// File: verilog/els_originator.sv
// Link service request originator: sends a request sequence, waits for
// the reply, and handles abort and retry toward the remote port.
// Assumes the link side takes words on o_tx_valid & i_tx_ready and
// reports reply, acknowledge and basic accept events as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "els_cfg.svh"

module els_originator
    import els_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // User request
    input wire logic i_start,
    input wire logic [7:0] i_cmd,
    input wire logic [1:0] i_class,
    input wire logic i_logged_in,
    input wire logic [4:0] i_req_len,
    input wire logic [31:0] i_req_word,
    input wire logic i_adv_valid2,
    input wire logic [`CRED_W-1:0] i_adv_credit2,
    input wire logic i_adv_valid3,
    input wire logic [`CRED_W-1:0] i_adv_credit3,
    // Timeout configuration in microseconds
    input wire logic [`TOV_W-1:0] i_ra_tov_us,
    input wire logic [`TOV_W-1:0] i_ed_tov_us,
    // User status
    output logic [4:0] o_req_index,
    output logic o_busy,
    output logic o_done,
    output logic o_accepted,
    output logic o_failed,
    // Link transmit
    input wire logic i_tx_ready,
    output logic o_tx_valid,
    output logic [31:0] o_tx_data,
    output logic o_tx_sof,
    output logic o_tx_eof,
    output logic o_tx_si,
    output logic [1:0] o_tx_class,
    output logic [15:0] o_tx_ox_id,
    output logic [7:0] o_tx_seq_id,
    output logic o_tx_discard_policy,
    output logic o_tx_default_login,
    // Link abort requests
    input wire logic i_abts_ready,
    output logic o_abts_valid,
    output logic o_abts_exchange,
    // Link receive events
    input wire logic i_rx_reply,
    input wire logic [7:0] i_rx_reply_code,
    input wire logic i_rx_reply_last,
    input wire logic i_rx_ack_abort,
    input wire logic i_rx_abts_ack,
    input wire logic i_rx_ba_acc
);

    orig_state_e state; // Sequencer state
    logic [7:0] cmd; // Latched command code
    logic logged_in; // Latched login state
    logic [4:0] total; // Words in this request
    logic [4:0] word_idx; // Next word to load
    logic [2:0] frame_cnt; // Word position in frame
    logic seq_retried; // Sequence retry used
    logic [1:0] exch_retries; // New exchanges used
    logic v2, v3; // Latched class validity
    logic [`CRED_W-1:0] c2, c3; // Latched credits
    logic tmr_start; // Timer reload pulse
    logic [`TOV_W:0] tmr_limit; // Timer reload value
    logic tmr_expired; // Timer expiry pulse

    // Credit advice payload word by index
    function automatic logic [31:0] advc_word(input logic [4:0] idx);
        logic [31:0] w;
        w = '0;
        unique case (idx)
            `ADVC_CMD_WORD: w = {`ELS_CMD_ADVC, `ELS_PAD_ZERO};
            `ADVC_C2_WORD0: w[`CLS_VALID_BIT] = v2;
            `ADVC_C2_CRED: w[`CRED_W-1:0] = c2;
            `ADVC_C3_WORD0: w[`CLS_VALID_BIT] = v3;
            `ADVC_C3_CRED: w[`CRED_W-1:0] = c3;
            default: w = '0;
        endcase
        return w;
    endfunction

    // Word selection and handshake decode
    wire is_advc = (cmd == `ELS_CMD_ADVC);
    wire [31:0] plain_word = (word_idx == 5'd0) ? {cmd, `ELS_PAD_ZERO} : i_req_word;
    wire [31:0] next_word = is_advc ? advc_word(word_idx) : plain_word;
    wire slot_free = !o_tx_valid || i_tx_ready;
    wire more_words = (word_idx < total);
    wire last_word = (word_idx == total - 5'd1);
    wire frame_end = (frame_cnt == `FRAME_WORDS) || last_word;
    wire timed_out = tmr_expired && !tmr_start;
    wire can_retry = (exch_retries != `MAX_EXCH_RETRY);
    wire [`TOV_W:0] reply_limit = {i_ra_tov_us, 1'b0};
    wire [`TOV_W:0] ed_limit = {1'b0, i_ed_tov_us};
    wire reply_ok = (i_rx_reply_code == `ELS_CODE_ACC);

    // Reply and acknowledge timer
    els_timer u_timer (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_start(tmr_start),
        .i_limit_us(tmr_limit),
        .o_expired(tmr_expired)
    );

    // Per-exchange attributes held for the whole exchange and its retries
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cmd <= '0;
            total <= '0;
            logged_in <= 1'b0;
            o_tx_class <= '0;
            {v2, v3, c2, c3} <= '0;
        end else if (state == ST_IDLE && i_start) begin
            cmd <= i_cmd;
            total <= (i_cmd == `ELS_CMD_ADVC) ? `ADVC_WORDS : i_req_len;
            logged_in <= i_logged_in;
            o_tx_class <= i_class;
            {v2, v3, c2, c3} <= {i_adv_valid2, i_adv_valid3, i_adv_credit2, i_adv_credit3};
        end
    end

    // Login-dependent link attributes
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_discard_policy <= 1'b0;
            o_tx_default_login <= 1'b1;
        end else begin
            o_tx_discard_policy <= logged_in;
            o_tx_default_login <= !logged_in;
        end
    end

    // Sequencer: send, wait, abort, retry
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            word_idx <= '0;
            frame_cnt <= '0;
            seq_retried <= 1'b0;
            exch_retries <= '0;
            o_tx_ox_id <= '0;
            o_tx_seq_id <= '0;
            o_tx_valid <= 1'b0;
            o_tx_data <= '0;
            o_tx_sof <= 1'b0;
            o_tx_eof <= 1'b0;
            o_tx_si <= 1'b0;
            o_abts_valid <= 1'b0;
            o_abts_exchange <= 1'b0;
            tmr_start <= 1'b0;
            tmr_limit <= '0;
            o_done <= 1'b0;
            o_accepted <= 1'b0;
            o_failed <= 1'b0;
        end else begin
            tmr_start <= 1'b0;
            o_done <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (i_start) begin
                        // Fresh exchange for every request
                        o_tx_ox_id <= o_tx_ox_id + 16'h0001;
                        o_tx_seq_id <= o_tx_seq_id + 8'h01;
                        word_idx <= '0;
                        frame_cnt <= '0;
                        seq_retried <= 1'b0;
                        exch_retries <= '0;
                        o_accepted <= 1'b0;
                        o_failed <= 1'b0;
                        state <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (slot_free && more_words) begin
                        // Frames of several words
                        o_tx_valid <= 1'b1;
                        o_tx_data <= next_word;
                        o_tx_sof <= (frame_cnt == 3'd0);
                        o_tx_eof <= frame_end;
                        o_tx_si <= last_word;
                        frame_cnt <= frame_end ? 3'd0 : frame_cnt + 3'd1;
                        word_idx <= word_idx + 5'd1;
                    end else if (slot_free) begin
                        // Last word gone: wait for reply
                        o_tx_valid <= 1'b0;
                        tmr_start <= 1'b1;
                        tmr_limit <= reply_limit;
                        state <= ST_WAIT_REPLY;
                    end
                end
                ST_WAIT_REPLY: begin
                    if (i_rx_reply && i_rx_reply_last) begin
                        // Reply closes the exchange
                        o_accepted <= reply_ok;
                        o_done <= 1'b1;
                        state <= ST_FINISH;
                    end else if (i_rx_ack_abort) begin
                        // Second abort on a retried sequence escalates
                        o_abts_valid <= 1'b1;
                        o_abts_exchange <= seq_retried;
                        state <= seq_retried ? ST_SEND_ABTS_LS : ST_SEND_ABTS;
                    end else if (timed_out) begin
                        o_abts_valid <= 1'b1;
                        o_abts_exchange <= 1'b1;
                        state <= ST_SEND_ABTS_LS;
                    end
                end
                ST_SEND_ABTS: begin
                    if (i_abts_ready) begin
                        o_abts_valid <= 1'b0;
                        tmr_start <= 1'b1;
                        tmr_limit <= ed_limit;
                        state <= ST_WAIT_ABTS_ACK;
                    end
                end
                ST_WAIT_ABTS_ACK: begin
                    if (i_rx_abts_ack) begin
                        tmr_start <= 1'b1;
                        tmr_limit <= ed_limit;
                        state <= ST_WAIT_BA;
                    end else if (timed_out) begin
                        o_abts_valid <= 1'b1;
                        o_abts_exchange <= 1'b1;
                        state <= ST_SEND_ABTS_LS;
                    end
                end
                ST_WAIT_BA: begin
                    if (i_rx_ba_acc) begin
                        // Single resend of the sequence, same exchange
                        seq_retried <= 1'b1;
                        o_tx_seq_id <= o_tx_seq_id + 8'h01;
                        word_idx <= '0;
                        frame_cnt <= '0;
                        state <= ST_SEND;
                    end else if (timed_out) begin
                        o_abts_valid <= 1'b1;
                        o_abts_exchange <= 1'b1;
                        state <= ST_SEND_ABTS_LS;
                    end
                end
                ST_SEND_ABTS_LS: begin
                    if (i_abts_ready) begin
                        o_abts_valid <= 1'b0;
                        tmr_start <= 1'b1;
                        tmr_limit <= ed_limit;
                        state <= ST_WAIT_LS_ACK;
                    end
                end
                ST_WAIT_LS_ACK: begin
                    // Acknowledged or timed out: new exchange if allowed
                    if (i_rx_abts_ack || timed_out) begin
                        if (can_retry) begin
                            o_tx_ox_id <= o_tx_ox_id + 16'h0001;
                            o_tx_seq_id <= o_tx_seq_id + 8'h01;
                            exch_retries <= exch_retries + 2'd1;
                            seq_retried <= 1'b0;
                            word_idx <= '0;
                            frame_cnt <= '0;
                            state <= ST_SEND;
                        end else begin
                            o_failed <= 1'b1;
                            o_done <= 1'b1;
                            state <= ST_FINISH;
                        end
                    end
                end
                ST_FINISH: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Index of the word loaded at the next edge, so the user's word lines up
    assign o_req_index = word_idx;

    // User-visible progress
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (state != ST_IDLE) || i_start;
        end
    end

endmodule // els_originator
`default_nettype wire

// File: testbench/els_originator_monitor.sv
// Checker for the link service originator; sees only its ports.
// Assumes it is bound to els_originator from the bench top file.
`timescale 1ns/1ps
`default_nettype none
`include "els_cfg.svh"

module els_originator_monitor (
    // Clock, reset and timer limits
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [`TOV_W-1:0] i_ra_tov_us,
    input wire logic [`TOV_W-1:0] i_ed_tov_us,
    // Login state offered with the request
    input wire logic i_logged_in,
    // Link events into the design
    input wire logic i_tx_ready,
    input wire logic i_abts_ready,
    input wire logic i_rx_reply,
    input wire logic [7:0] i_rx_reply_code,
    input wire logic i_rx_reply_last,
    input wire logic i_rx_ack_abort,
    // Design outputs
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_accepted,
    input wire logic o_tx_valid,
    input wire logic [31:0] o_tx_data,
    input wire logic o_tx_sof,
    input wire logic o_tx_eof,
    input wire logic o_tx_si,
    input wire logic [1:0] o_tx_class,
    input wire logic o_tx_discard_policy,
    input wire logic o_tx_default_login,
    input wire logic o_abts_valid,
    input wire logic o_abts_exchange
);
    // Busy with nothing offered on the link: a timed wait
    wire quiet = o_busy && !o_tx_valid && !o_abts_valid;
    // Twice the allocation limit and the detect limit
    wire [31:0] ra2 = {7'h00, i_ra_tov_us, 1'h0};
    wire [31:0] ed = {8'h00, i_ed_tov_us};
    // Longest legal wait: larger limit plus one tick and 8 cycles of slack
    wire [31:0] wait_lim = 32'd250 * ((ra2 > ed ? ra2 : ed) + 32'h1) + 32'h8;
    logic [31:0] wait_cnt; // Length of the current quiet wait

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // Count quiet cycles, restart on any link activity
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_cnt <= 32'h0;
        end else begin
            wait_cnt <= quiet ? wait_cnt + 32'h1 : 32'h0;
        end
    end

    a_first_word_sof: assert property ($rose(o_tx_valid) |-> o_tx_sof)
        else $error("word stream opened without a frame start");
    a_word_holds: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid
        && $stable(o_tx_data) && $stable({o_tx_sof, o_tx_eof, o_tx_si}))
        else $error("offered word changed before it was taken");
    a_si_on_eof: assert property (o_tx_valid && o_tx_si |-> o_tx_eof)
        else $error("initiative passed outside a frame end");
    a_class_steady: assert property (o_busy [*2] |-> $stable(o_tx_class))
        else $error("class changed inside a request");
    a_policy_login: assert property (o_tx_discard_policy != o_tx_default_login)
        else $error("policy and default login flags disagree");
    a_policy_latched: assert property ($rose(o_busy) |=> o_tx_discard_policy == $past(i_logged_in, 2))
        else $error("error policy does not follow the login state at start");
    a_reply_done: assert property (quiet && i_rx_reply && i_rx_reply_last |=> o_done
        && (o_accepted == ($past(i_rx_reply_code) == 8'h02)))
        else $error("reply not finished with the right verdict");
    a_ack_abort_abts: assert property (quiet && i_rx_ack_abort |=> o_abts_valid)
        else $error("abort-bits ack not followed by an abort");
    a_abts_held: assert property (o_abts_valid && !i_abts_ready |=> o_abts_valid
        && $stable(o_abts_exchange))
        else $error("abort request dropped before it was taken");
    a_done_pulse: assert property (o_done |=> !o_done)
        else $error("done lasted more than one cycle");
    a_reply_timer: assert property (wait_cnt <= wait_lim)
        else $error("wait ran past its timeout");
    a_idle_quiet: assert property (!o_busy |-> !o_tx_valid && !o_abts_valid)
        else $error("link activity while idle");
endmodule // els_originator_monitor

`default_nettype wire

// File: testbench/els_remote_port.sv
// Behavioural remote port answering the originator's requests.
// Assumes the bench picks the answer style through i_mode.
`timescale 1ns/1ps
`default_nettype none

module els_remote_port (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Answer style and stall choice
    input wire logic [2:0] i_mode,
    input wire logic i_stall,
    // From the originator
    input wire logic i_tx_valid,
    input wire logic i_tx_si,
    input wire logic i_abts_valid,
    input wire logic i_abts_exchange,
    // To the originator
    output logic o_tx_ready,
    output logic o_abts_ready,
    output logic o_rx_reply,
    output logic [7:0] o_rx_reply_code,
    output logic o_rx_reply_last,
    output logic o_rx_ack_abort,
    output logic o_rx_abts_ack,
    output logic o_rx_ba_acc
);
    int rdly; // Countdown to the reply event
    int adly; // Countdown to the abort acknowledge
    int bdly; // Countdown to the basic accept
    logic ab_kind; // Pending abort is an exchange abort
    logic last_ab; // Last answer was an abort-bits ack
    logic [3:0] tick; // Free counter for slow acceptance

    // One process: pulses, stalls and delayed answers
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {rdly, adly, bdly} = 0;
            {ab_kind, last_ab, tick} = 6'h0;
            {o_tx_ready, o_abts_ready, o_rx_reply, o_rx_reply_last} <= 4'h0;
            {o_rx_ack_abort, o_rx_abts_ack, o_rx_ba_acc, o_rx_reply_code} <= 11'h0;
        end else begin
            // Events last one cycle; qualifiers do not linger
            {o_abts_ready, o_rx_reply, o_rx_reply_last} <= 3'h0;
            {o_rx_ack_abort, o_rx_abts_ack, o_rx_ba_acc} <= 3'h0;
            o_rx_reply_code <= ~o_rx_reply_code;
            tick = tick + 4'h1;
            o_tx_ready <= !i_stall || tick[1:0] == 2'h0;
            // Whole sequence with initiative gets an answer
            if (i_tx_valid && o_tx_ready && i_tx_si) rdly = 4;
            if (rdly == 1) begin
                if (i_mode == 3'h3) begin
                    // Silent: the originator must time out
                end else if (i_mode == 3'h4 || (i_mode[1] ^ i_mode[0]) && i_mode != 3'h1
                             && !last_ab) begin
                    o_rx_ack_abort <= 1'h1;
                    last_ab = 1'h1;
                end else begin
                    o_rx_reply <= 1'h1;
                    o_rx_reply_last <= 1'h1;
                    o_rx_reply_code <= (i_mode == 3'h1) ? 8'h01 : 8'h02;
                    last_ab = 1'h0;
                end
            end
            // Take an abort; mode 5 never acks a sequence abort
            if (i_abts_valid && !o_abts_ready && adly == 0) begin
                o_abts_ready <= 1'h1;
                ab_kind = i_abts_exchange;
                adly = (i_mode == 3'h5 && !i_abts_exchange) ? 0 : 3;
            end else if (adly == 1) begin
                o_rx_abts_ack <= 1'h1;
                bdly = ab_kind ? 0 : 3;
            end
            if (bdly == 1) o_rx_ba_acc <= 1'h1;
            if (rdly > 0) rdly = rdly - 1;
            if (adly > 0 && !o_abts_ready) adly = adly - 1;
            if (bdly > 0) bdly = bdly - 1;
        end
    end
endmodule // els_remote_port

`default_nettype wire

// File: testbench/tb_els_originator.sv
// Self-checking bench for the link service originator.
// Assumes design, remote port model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "els_cfg.svh"

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_els_originator;
    import els_pkg::*;
    logic i_clock, i_rst_n, i_start, i_logged_in, i_adv_valid2, i_adv_valid3;
    logic [7:0] i_cmd, i_rx_reply_code, o_tx_seq_id, last_seq;
    logic [1:0] i_class, o_tx_class, cls;
    logic [4:0] i_req_len, o_req_index;
    logic [31:0] i_req_word, o_tx_data, rng;
    logic [15:0] i_adv_credit2, i_adv_credit3, o_tx_ox_id, last_ox;
    logic [`TOV_W-1:0] i_ra_tov_us, i_ed_tov_us;
    logic o_busy, o_done, o_accepted, o_failed, i_tx_ready, o_tx_valid, o_tx_sof;
    logic o_tx_eof, o_tx_si, o_tx_discard_policy, o_tx_default_login, i_abts_ready;
    logic o_abts_valid, o_abts_exchange, i_rx_reply, i_rx_reply_last, i_rx_ack_abort;
    logic i_rx_abts_ack, i_rx_ba_acc, lin, stall;
    logic [2:0] mode;
    logic [26:0] wbase; // Filler pattern of request words
    logic [31:0] exp_w [0:31]; // Expected request sequence
    int exp_n, widx, nseq, err_count, n_compared;

    // Payload word follows the index the design asks for
    assign i_req_word = {wbase, o_req_index};

    els_originator dut (.*);

    els_remote_port peer (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_mode(mode),
        .i_stall(stall), .i_tx_valid(o_tx_valid), .i_tx_si(o_tx_si),
        .i_abts_valid(o_abts_valid), .i_abts_exchange(o_abts_exchange),
        .o_tx_ready(i_tx_ready), .o_abts_ready(i_abts_ready), .o_rx_reply(i_rx_reply),
        .o_rx_reply_code(i_rx_reply_code), .o_rx_reply_last(i_rx_reply_last),
        .o_rx_ack_abort(i_rx_ack_abort), .o_rx_abts_ack(i_rx_abts_ack),
        .o_rx_ba_acc(i_rx_ba_acc));

    // Clock at 250 MHz
    initial begin
        i_clock = 1'h0;
        forever #2 i_clock = ~i_clock;
    end

    // Xorshift source for stimulus
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Closing report and end of run
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Word checker against the model sequence
    always @(posedge i_clock) begin
        if (i_rst_n && o_tx_valid && i_tx_ready) begin
            `CHK({o_tx_data, o_tx_sof, o_tx_eof, o_tx_si}, {exp_w[widx], widx % 8 == 0, widx % 8 == 7 || widx == exp_n - 1, widx == exp_n - 1})
            `CHK({o_tx_class, o_tx_discard_policy, o_tx_default_login}, {cls, lin, !lin})
            if (widx == 0) begin
                // Same exchange: sequence retry; else a fresh exchange
                if (nseq > 0 && o_tx_ox_id === last_ox) `CHK(o_tx_seq_id, last_seq + 8'h01)
                else `CHK(o_tx_ox_id, last_ox + 16'h0001)
                last_ox = o_tx_ox_id;
                last_seq = o_tx_seq_id;
            end
            nseq = (widx == exp_n - 1) ? nseq + 1 : nseq;
            widx = (widx == exp_n - 1) ? 0 : widx + 1;
        end
    end

    // One request under a chosen answer style
    task automatic run_one(input logic [2:0] md, input logic adv);
        int i;
        rng = xs(rng);
        exp_n = adv ? 29 : 1 + rng[3:0] + rng[7:4];
        for (i = 0; i < 32; i++) exp_w[i] = adv ? 32'h0 : {rng[26:0], i[4:0]};
        exp_w[0] = {adv ? 8'h0D : {2'h1, rng[13:8]}, 24'h000000};
        if (adv) begin
            exp_w[13] = {rng[20], 31'h0};
            exp_w[15] = {16'h0, rng[31:16]};
            exp_w[17] = {rng[19], 31'h0};
            exp_w[19] = {16'h0, rng[15:0]};
        end
        {widx, nseq} = 0;
        cls = rng[17:16];
        lin = rng[18];
        @(posedge i_clock);
        {i_cmd, i_class, i_logged_in, wbase} <= {exp_w[0][31:24], cls, lin, rng[26:0]};
        {i_adv_valid2, i_adv_valid3, i_adv_credit2, i_adv_credit3} <= {rng[20:19], rng};
        {i_req_len, mode, stall, i_start} <= {exp_n[4:0], md, rng[21], 1'h1};
        @(posedge i_clock);
        i_start <= 1'h0;
        for (i = 0; i < 20000 && o_done !== 1'h1; i++) @(negedge i_clock);
        if (i == 20000) begin
            err_count++;
            give_verdict();
        end
        `CHK({o_accepted, o_failed}, {md == 0 || md == 2 || md == 5, md == 3 || md == 4})
        if (md < 3 || md == 5) `CHK(nseq, (md == 2 || md == 5) ? 2 : 1)
        $display("request mode %0d advice %0d over", md, adv);
        repeat (3) @(posedge i_clock);
    endtask

    // Main sequence: reset, idle values, table of requests
    initial begin
        logic [2:0] modes [0:6] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h5, 3'h3, 3'h4};
        {i_rst_n, i_start, i_cmd, i_class, i_logged_in, i_req_len, wbase} = 0;
        {i_adv_valid2, i_adv_valid3, i_adv_credit2, i_adv_credit3, mode, stall} = 0;
        {err_count, n_compared, exp_n, widx, nseq} = 0;
        {i_ra_tov_us, i_ed_tov_us} = {24'h000002, 24'h000003};
        {last_ox, last_seq, cls, lin} = 0;
        rng = 32'h0000003C;
        repeat (10) @(posedge i_clock);
        i_rst_n <= 1'h1;
        @(negedge i_clock);
        `CHK({o_busy, o_done, o_tx_valid, o_abts_valid, o_tx_default_login}, 5'h01)
        for (int r = 0; r < 2; r++) begin
            for (int t = 0; t < 7; t++) run_one(modes[t], t == 0 || t == 3);
        end
        give_verdict();
    end
endmodule // tb_els_originator

bind els_originator els_originator_monitor mon (.*);

`default_nettype wire
